// file: parallel_printer_port.sv
// parallel printer output port: data latch, strobe, restart, status, ack request
// assumes a simple synchronous processor bus with one-cycle read/write strobes
// What this block does
// - eight-bit latch drives printer data lines
// - write sets, read clears strobe and restart
// - data-address read returns printer status bits
// - bits six, five show serial line indicators
// - jumpers pick ring or carrier detect
// - falling acknowledge sets request to timer chip
// - read of clear address drops request
// - power-on: strobe, restart inactive
// - reset: outputs inactive, latch kept
`timescale 1ns/1ps
`default_nettype none
`include "pport_cfg.svh"
module parallel_printer_port (
   input  wire logic                  MCLK,
   input  wire logic                  NRST,
   input  wire logic                  CE,
   input  wire logic [`PP_ADDR_W-1:0] ADDR,
   input  wire logic                  RD,
   input  wire logic                  WR,
   input  wire logic [7:0]            WDATA,
   output logic      [7:0]            RDATA,
   output logic      [7:0]            PRINTER_DATA,
   output logic                       STROBE_N,
   output logic                       RESTART_N,
   input  wire logic                  ACK_N,
   input  wire logic                  BUSY,
   input  wire logic                  PAPER_EMPTY,
   input  wire logic                  SELECTED,
   input  wire logic                  FAULT_N,
   input  wire logic                  SERIAL_A_RING,
   input  wire logic                  SERIAL_A_CARRIER,
   input  wire logic                  SERIAL_B_RING,
   input  wire logic                  SERIAL_B_CARRIER,
   input  wire logic                  JUMPER_A_CARRIER,
   input  wire logic                  JUMPER_B_CARRIER,
   output logic                       ACK_REQUEST_INPUT_BIT
);
   // ******************************************************************
   // input synchronisation
   // ******************************************************************
   localparam int NSYNC = 11;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync_in;
   logic             ack_s;
   logic             ack_n_s;
   logic             busy_s;
   logic             paper_empty;
   logic             sel_s;
   logic             fault_n_s;
   logic             ra_s;
   logic             ca_s;
   logic             rb_s;
   logic             cb_s;
   logic             jsa_s;
   logic             jsb_s;

   // acknowledge enters inverted: flops reset to its idle level, no false edge
   assign raw_in = {~ACK_N, BUSY, PAPER_EMPTY, SELECTED, FAULT_N,
                    SERIAL_A_RING, SERIAL_A_CARRIER, SERIAL_B_RING, SERIAL_B_CARRIER,
                    JUMPER_A_CARRIER, JUMPER_B_CARRIER};

   pport_sync #(.W(NSYNC)) u_sync (
      .clk  (MCLK),
      .nrst (NRST),
      .ce   (CE),
      .d    (raw_in),
      .q    (sync_in)
   );

   assign {ack_s, busy_s, paper_empty, sel_s, fault_n_s,
           ra_s, ca_s, rb_s, cb_s, jsa_s, jsb_s} = sync_in;
   assign ack_n_s = ~ack_s;

   // ******************************************************************
   // jumper straps, registered from their synchronised pins
   // ******************************************************************
   logic jmp_a;
   logic jmp_b;
   logic next_jmp_a;
   logic next_jmp_b;

   // straps are static, so following them continuously costs nothing
   always_comb begin
      next_jmp_a = jsa_s;
      next_jmp_b = jsb_s;
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         jmp_a <= 1'b0;
         jmp_b <= 1'b0;
      end else if (CE) begin
         jmp_a <= next_jmp_a;
         jmp_b <= next_jmp_b;
      end
   end

   // ******************************************************************
   // address decode
   // ******************************************************************
   pport_pkg::access_t acc;
   logic hit_data;
   logic hit_strobe;
   logic hit_restart;
   logic hit_ackclr;

   always_comb begin
      if (WR) begin
         acc = pport_pkg::ACC_WRITE;
      end else if (RD) begin
         acc = pport_pkg::ACC_READ;
      end else begin
         acc = pport_pkg::ACC_NONE;
      end
      hit_data    = (ADDR == `PP_ADDR_DATA);
      hit_strobe  = (ADDR == `PP_ADDR_STROBE);
      hit_restart = (ADDR == `PP_ADDR_RESTART);
      hit_ackclr  = (ADDR == `PP_ADDR_ACKCLR);
   end

   // ******************************************************************
   // data latch (not reset by board reset)
   // ******************************************************************
   logic [7:0] latch;
   logic [7:0] next_latch;

   always_comb begin
      next_latch = latch;
      if (acc == pport_pkg::ACC_WRITE && hit_data) begin
         next_latch = WDATA;
      end
   end

   // latch keeps its value across reset; contents undefined at power-on
   always_ff @(posedge MCLK) begin
      if (CE) begin
         latch <= next_latch;
      end
   end

   assign PRINTER_DATA = latch;

   // ******************************************************************
   // handshake outputs
   // ******************************************************************
   logic strobe_on;
   logic restart_on;
   logic next_strobe_on;
   logic next_restart_on;

   always_comb begin
      next_strobe_on  = strobe_on;
      next_restart_on = restart_on;
      if (hit_strobe) begin
         unique case (acc)
            pport_pkg::ACC_WRITE: next_strobe_on = 1'b1;
            pport_pkg::ACC_READ:  next_strobe_on = 1'b0;
            pport_pkg::ACC_NONE:  next_strobe_on = strobe_on;
         endcase
      end
      if (hit_restart) begin
         unique case (acc)
            pport_pkg::ACC_WRITE: next_restart_on = 1'b1;
            pport_pkg::ACC_READ:  next_restart_on = 1'b0;
            pport_pkg::ACC_NONE:  next_restart_on = restart_on;
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         strobe_on  <= 1'b0;
         restart_on <= 1'b0;
      end else if (CE) begin
         strobe_on  <= next_strobe_on;
         restart_on <= next_restart_on;
      end
   end

   assign STROBE_N  = ~strobe_on;
   assign RESTART_N = ~restart_on;

   // ******************************************************************
   // acknowledge request
   // ******************************************************************
   logic ack_clear;
   assign ack_clear = CE && (acc == pport_pkg::ACC_READ) && hit_ackclr;

   pport_ackflag u_ack (
      .clk        (MCLK),
      .nrst       (NRST),
      .ce         (CE),
      .ack_n_sync (ack_n_s),
      .clear      (ack_clear),
      .pending    (ACK_REQUEST_INPUT_BIT)
   );

   // ******************************************************************
   // read data
   // ******************************************************************
   logic [7:0] status;
   logic [7:0] next_rdata;

   always_comb begin
      status                = 8'h00;
      status[`PP_ST_ACK]    = ack_n_s;
      status[`PP_ST_BUSY]   = busy_s;
      status[`PP_ST_PAPER]  = paper_empty;
      status[`PP_ST_SELECT] = sel_s;
      status[`PP_ST_FAULT]  = fault_n_s;
      status[`PP_ST_SERA]   = jmp_a ? ca_s : ra_s;
      status[`PP_ST_SERB]   = jmp_b ? cb_s : rb_s;
      status[`PP_ST_SPARE]  = 1'b0;
      next_rdata = RDATA;
      if (acc == pport_pkg::ACC_READ) begin
         next_rdata = hit_data ? status : 8'h00;
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         RDATA <= 8'h00;
      end else if (CE) begin
         RDATA <= next_rdata;
      end
   end

   // ******************************************************************
   // checks
   // ******************************************************************
   AST_STROBE_ON: assert property (@(posedge MCLK) disable iff (!NRST)
      CE && WR && hit_strobe |=> !STROBE_N)
      else $error("strobe not asserted by write");
   AST_STROBE_OFF: assert property (@(posedge MCLK) disable iff (!NRST)
      CE && RD && !WR && hit_strobe |=> STROBE_N)
      else $error("strobe not negated by read");
   AST_RESTART_ON: assert property (@(posedge MCLK) disable iff (!NRST)
      CE && WR && hit_restart |=> !RESTART_N)
      else $error("restart not asserted by write");
   AST_LATCH: assert property (@(posedge MCLK) disable iff (!NRST)
      CE && WR && hit_data |=> PRINTER_DATA == $past(WDATA))
      else $error("latch did not load");
   AST_STATUS: assert property (@(posedge MCLK) disable iff (!NRST)
      CE && RD && !WR && hit_data |=> RDATA[`PP_ST_BUSY] == $past(busy_s))
      else $error("status busy wrong");
   AST_ACK_CLEAR: assert property (@(posedge MCLK) disable iff (!NRST)
      ack_clear && ack_n_s |=> !ACK_REQUEST_INPUT_BIT)
      else $error("request not cleared");
   AST_STROBE_STEADY: assert property (@(posedge MCLK) disable iff (!NRST)
      CE && !hit_strobe |=> STROBE_N == $past(STROBE_N))
      else $error("strobe changed without access");
   AST_SER_A: assert property (@(posedge MCLK) disable iff (!NRST)
      CE && RD && !WR && hit_data |=>
         RDATA[`PP_ST_SERA] == ($past(jmp_a) ? $past(ca_s) : $past(ra_s)))
      else $error("serial a indicator wrong");

   // ******************************************************************
   // multi-step checks
   // ******************************************************************
   // acknowledge high then low on two enabled edges
   sequence s_ack_fall;
      (CE && ack_n_s) ##1 (CE && !ack_n_s);
   endsequence
   // enabled read of the data address
   sequence s_status_read;
      CE && RD && !WR && hit_data;
   endsequence

   AST_RESTART_OFF: assert property (@(posedge MCLK) disable iff (!NRST)
      CE && RD && !WR && hit_restart |=> RESTART_N)
      else $error("restart not negated by read");
   AST_RESTART_STEADY: assert property (@(posedge MCLK) disable iff (!NRST)
      CE && !hit_restart |=> $stable(RESTART_N))
      else $error("restart changed without access");
   AST_STATUS_LOW: assert property (@(posedge MCLK) disable iff (!NRST)
      s_status_read |=> RDATA[`PP_ST_FAULT] == $past(fault_n_s) &&
         RDATA[`PP_ST_SELECT] == $past(sel_s) && RDATA[`PP_ST_PAPER] == $past(paper_empty) &&
         RDATA[`PP_ST_ACK] == $past(ack_n_s))
      else $error("status low bits wrong");
   AST_STATUS_SPARE: assert property (@(posedge MCLK) disable iff (!NRST)
      s_status_read |=> !RDATA[`PP_ST_SPARE])
      else $error("status spare bit set");
   AST_SER_B: assert property (@(posedge MCLK) disable iff (!NRST)
      s_status_read |=> RDATA[`PP_ST_SERB] == ($past(jmp_b) ? $past(cb_s) : $past(rb_s)))
      else $error("serial b indicator wrong");
   AST_UNMAPPED_READ: assert property (@(posedge MCLK) disable iff (!NRST)
      CE && RD && !WR && !hit_data |=> RDATA == 8'h00)
      else $error("non-status read returned data");
   AST_RDATA_HOLD: assert property (@(posedge MCLK) disable iff (!NRST)
      !(CE && RD && !WR) |=> $stable(RDATA))
      else $error("read data changed without read");
   AST_ACK_EDGE: assert property (@(posedge MCLK) disable iff (!NRST)
      s_ack_fall |=> ACK_REQUEST_INPUT_BIT)
      else $error("ack fall did not raise request");
   AST_REQ_CAUSE: assert property (@(posedge MCLK) disable iff (!NRST)
      $rose(ACK_REQUEST_INPUT_BIT) && $past(CE, 2) |->
         !$past(ack_n_s) && $past(ack_n_s, 2))
      else $error("request rose without ack fall");
endmodule : parallel_printer_port
`default_nettype wire

// file: pport_cfg.svh
// constants for the parallel printer port: addresses, status bit positions
// assumes inclusion by bare name from the port module and the bench
`ifndef PPORT_CFG_SVH
`define PPORT_CFG_SVH
`define PP_ADDR_W         24
`define PP_ADDR_DATA      24'hFE6000
`define PP_ADDR_STROBE    24'hFE6002
`define PP_ADDR_RESTART   24'hFE6004
`define PP_ADDR_ACKCLR    24'hFE6006
`define PP_ST_ACK         0
`define PP_ST_BUSY        1
`define PP_ST_PAPER       2
`define PP_ST_SELECT      3
`define PP_ST_FAULT       4
`define PP_ST_SERB        5
`define PP_ST_SERA        6
`define PP_ST_SPARE       7
`endif

// file: pport_pkg.sv
// types shared by the parallel printer port
// assumes pport_cfg.svh defines the numeric constants
`default_nettype none
package pport_pkg;
   typedef enum logic [1:0] {ACC_NONE, ACC_READ, ACC_WRITE} access_t;
endpackage : pport_pkg
`default_nettype wire

// file: pport_sync.sv
// two flip-flop synchroniser, one generate entry per bit
// assumes asynchronous active-low reset and a clock enable
`timescale 1ns/1ps
`default_nettype none
module pport_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic stage1;
         logic stage2;
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               stage1 <= 1'b0;
               stage2 <= 1'b0;
            end else if (ce) begin
               stage1 <= d[i];
               stage2 <= stage1;
            end
         end
         assign q[i] = stage2;
      end
   endgenerate
endmodule : pport_sync
`default_nettype wire

// file: pport_ackflag.sv
// acknowledge request flag: falling edge sets, clear pulse clears, set wins
// assumes ack input already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module pport_ackflag (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic ce,
   input  wire logic ack_n_sync,
   input  wire logic clear,
   output logic      pending
);
   logic ack_prev;
   logic next_ack_prev;
   logic next_pending;
   logic fall;

   always_comb begin
      fall          = ack_prev & ~ack_n_sync;
      next_ack_prev = ack_n_sync;
      next_pending  = fall | (pending & ~clear);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_prev <= 1'b1;
         pending  <= 1'b0;
      end else if (ce) begin
         ack_prev <= next_ack_prev;
         pending  <= next_pending;
      end
   end

   AST_ACK_SET: assert property (@(posedge clk) disable iff (!nrst)
      ce && fall |=> pending)
      else $error("ack edge did not set request");
   AST_ACK_HOLD: assert property (@(posedge clk) disable iff (!nrst)
      ce && pending && !clear |=> pending)
      else $error("request dropped without clear");
endmodule : pport_ackflag
`default_nettype wire

// file: printer_model.sv
// behavioural printer on the far side of the parallel port
// assumes strobe_n and data come from the port, clk is the board clock
`timescale 1ns/1ps
`default_nettype none
module printer_model #(
   parameter int ACK_DELAY = 6,
   parameter int ACK_WIDTH = 5
) (
   input  wire logic       clk,
   input  wire logic       strobe_n,
   input  wire logic [7:0] data,
   output logic            ack_n,
   output logic            busy,
   output logic [7:0]      last_char
);
   logic prev_n;
   initial begin
      ack_n = 1'b1;
      busy = 1'b0;
      last_char = 8'h00;
      prev_n = 1'b1;
   end
   // take the character on strobe release, then busy and ack pulse
   always @(posedge clk) begin
      if (prev_n === 1'b0 && strobe_n === 1'b1) begin
         last_char = data;
         busy <= 1'b1;
         repeat (ACK_DELAY) @(posedge clk);
         ack_n <= 1'b0;
         repeat (ACK_WIDTH) @(posedge clk);
         ack_n <= 1'b1;
         busy <= 1'b0;
      end
      prev_n = strobe_n;
   end
endmodule : printer_model
`default_nettype wire

// file: parallel_printer_port_tb_top.sv
// self-checking bench for the parallel printer port
// assumes printer_model answers strobes; straps set before reset, changed once in t_status
`timescale 1ns/1ps
`default_nettype none
`include "pport_cfg.svh"
module parallel_printer_port_tb_top;
   logic        mclk, nrst, ce, rd, wr, paper, sel, fault_n, a_ri, a_cd, b_ri, b_cd;
   logic        jmp_a, jmp_b, ack_n, busy, req, strobe_n, restart_n;
   logic [23:0] addr;
   logic [7:0]  wdata, rdata, pdata, seen, got;
   int          num_errors, num_checks, i;
   initial mclk = 1'b0;
   always #2 mclk = ~mclk;
   parallel_printer_port u_parallel_printer_port (
      .MCLK(mclk), .NRST(nrst), .CE(ce), .ADDR(addr), .RD(rd), .WR(wr),
      .WDATA(wdata), .RDATA(rdata), .PRINTER_DATA(pdata), .STROBE_N(strobe_n),
      .RESTART_N(restart_n), .ACK_N(ack_n), .BUSY(busy), .PAPER_EMPTY(paper),
      .SELECTED(sel), .FAULT_N(fault_n), .SERIAL_A_RING(a_ri),
      .SERIAL_A_CARRIER(a_cd), .SERIAL_B_RING(b_ri), .SERIAL_B_CARRIER(b_cd),
      .JUMPER_A_CARRIER(jmp_a), .JUMPER_B_CARRIER(jmp_b),
      .ACK_REQUEST_INPUT_BIT(req));
   printer_model u_printer_model (
      .clk(mclk), .strobe_n(strobe_n), .data(pdata), .ack_n(ack_n), .busy(busy),
      .last_char(seen));
   // ***********************************
   // shared tasks
   // ***********************************
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] act);
      num_checks++;
      if (act !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, act);
      end
   endtask : chk
   task automatic bus_wr(input logic [23:0] a, input logic [7:0] d);
      @(negedge mclk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge mclk);
      wr = 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [23:0] a);
      @(negedge mclk);
      addr = a;
      rd = 1'b1;
      @(negedge mclk);
      rd = 1'b0;
      got = rdata;
   endtask : bus_rd
   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   // ***********************************
   // scenarios
   // ***********************************
   task automatic t_after_reset;
      chk("strobe_n", 8'h01, {7'h00, strobe_n});
      chk("restart_n", 8'h01, {7'h00, restart_n});
      chk("ack_req", 8'h00, {7'h00, req});
      $display("test after_reset done");
   endtask : t_after_reset
   task automatic t_latch_ctrl;
      bus_wr(`PP_ADDR_DATA, 8'h41);
      chk("latch", 8'h41, pdata);
      bus_wr(24'hFE6008, 8'hFF);
      chk("latch unmapped", 8'h41, pdata);
      bus_wr(`PP_ADDR_STROBE, 8'h00);
      chk("strobe on", 8'h00, {7'h00, strobe_n});
      bus_wr(`PP_ADDR_RESTART, 8'h00);
      chk("restart on", 8'h00, {7'h00, restart_n});
      bus_rd(`PP_ADDR_STROBE);
      chk("strobe off", 8'h01, {7'h00, strobe_n});
      chk("restart kept", 8'h00, {7'h00, restart_n});
      bus_rd(`PP_ADDR_RESTART);
      chk("restart off", 8'h01, {7'h00, restart_n});
      bus_rd(24'hFE6008);
      chk("unmapped read", 8'h00, got);
      for (i = 0; i < 50 && busy !== 1'b0; i++) @(negedge mclk);
      chk("stray print", 8'h41, seen);
      chk("stray ack_req", 8'h01, {7'h00, req});
      bus_rd(`PP_ADDR_ACKCLR);
      chk("stray ack_req clear", 8'h00, {7'h00, req});
      $display("test latch_ctrl done");
   endtask : t_latch_ctrl
   task automatic t_status;
      {paper, sel, fault_n, a_cd, a_ri, b_ri, b_cd} = 7'b1001010;
      repeat (4) @(negedge mclk);
      bus_rd(`PP_ADDR_DATA);
      chk("status 1", 8'h65, got);
      {paper, sel, fault_n, a_cd, a_ri, b_ri, b_cd} = 7'b0110101;
      repeat (4) @(negedge mclk);
      bus_rd(`PP_ADDR_DATA);
      chk("status 2", 8'h19, got);
      {jmp_a, jmp_b, paper, sel, fault_n, a_cd, a_ri, b_ri, b_cd} = 9'b011001010;
      repeat (4) @(negedge mclk);
      bus_rd(`PP_ADDR_DATA);
      chk("status 3", 8'h05, got);
      $display("test status done");
   endtask : t_status
   task automatic t_print(input logic [7:0] c);
      got = 8'hFF;
      for (i = 0; i < 100 && got[`PP_ST_BUSY] !== 1'b0; i++) bus_rd(`PP_ADDR_DATA);
      bus_wr(`PP_ADDR_DATA, c);
      bus_wr(`PP_ADDR_STROBE, 8'h00);
      repeat (250) @(negedge mclk);
      bus_rd(`PP_ADDR_STROBE);
      for (i = 0; i < 50 && req !== 1'b1; i++) @(negedge mclk);
      chk("ack_req set", 8'h01, {7'h00, req});
      chk("printed", c, seen);
      for (i = 0; i < 50 && busy !== 1'b0; i++) @(negedge mclk);
      repeat (5) @(negedge mclk);
      chk("ack_req sticky", 8'h01, {7'h00, req});
      bus_rd(`PP_ADDR_ACKCLR);
      chk("ack_req clear", 8'h00, {7'h00, req});
      $display("test print done");
   endtask : t_print
   task automatic t_reset_keeps_latch;
      bus_wr(`PP_ADDR_DATA, 8'h5A);
      bus_wr(`PP_ADDR_STROBE, 8'h00);
      bus_wr(`PP_ADDR_RESTART, 8'h00);
      nrst = 1'b0;
      @(negedge mclk);
      chk("reset strobe_n", 8'h01, {7'h00, strobe_n});
      chk("reset restart_n", 8'h01, {7'h00, restart_n});
      chk("reset latch", 8'h5A, pdata);
      nrst = 1'b1;
      repeat (2) @(negedge mclk);
      chk("release ack_req", 8'h00, {7'h00, req});
      $display("test reset_keeps_latch done");
   endtask : t_reset_keeps_latch
   initial begin
      {nrst, ce, rd, wr, addr, wdata} = {1'b0, 1'b1, 34'h0};
      {jmp_a, jmp_b, paper, sel, fault_n, a_ri, a_cd, b_ri, b_cd} = 9'b100010000;
      num_errors = 0;
      num_checks = 0;
      repeat (6) @(negedge mclk);
      nrst = 1'b1;
      @(negedge mclk);
      t_after_reset();
      t_latch_ctrl();
      t_status();
      t_print(8'h41);
      t_print(8'hC3);
      t_reset_keeps_latch();
      give_verdict();
   end
   initial begin
      #20000;
      num_errors++;
      give_verdict();
   end
endmodule : parallel_printer_port_tb_top
`default_nettype wire
